// >>> inc/pma_pkg.sv
// Shared types and constants of the physical memory attribution checker.
package pma_pkg;

  typedef struct packed {
    logic [31:0] wordAddrLow;
    logic [31:0] wordAddrHigh;
    logic        main;
    logic        bufferable;
    logic        cacheable;
    logic        integrity;
  } pma_region_t;

  localparam int MAX_REGIONS = 16;

  // Access kinds presented by the fetch and load-store units.
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_LOAD  = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;

  // Access sizes.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Exception codes.
  localparam logic [4:0] EXC_NONE         = 5'h00;
  localparam logic [4:0] EXC_INSTR_ACCESS = 5'h01;
  localparam logic [4:0] EXC_LOAD_ACCESS  = 5'h05;
  localparam logic [4:0] EXC_STORE_ACCESS = 5'h07;

  // Memory-type bit positions on the bus.
  localparam int MEMTYPE_BUF_BIT   = 0;
  localparam int MEMTYPE_CACHE_BIT = 1;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h08;

  // Field positions and reset values.
  localparam int          CTRL_INTEGRITY_BIT = 0;
  localparam int          STATUS_INTEG_BIT   = 0;
  localparam int          STATUS_FAULT_BIT   = 1;
  localparam int          STATUS_CODE_LSB    = 8;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0001;
  localparam logic [31:0] FAULT_ADDR_RESET   = 32'h0000_0000;

  // Default debug window, an arbitrary plain range.
  localparam logic [31:0] DEBUG_BASE_DEFAULT  = 32'h0000_8000;
  localparam logic [31:0] DEBUG_LIMIT_DEFAULT = 32'h0000_8FFF;

endpackage

// >>> design/pma_checker.sv
// Physical memory attribution checker with its AHB-Lite control registers.
//
// How it works
// - Region count is a parameter from zero to sixteen, each with bounds and flags.
// - Overlapping regions resolve to the lowest-index region.
// - Match when low bound times four <= address < high bound times four.
// - Main regions allow execution, misaligned and modified accesses; idempotent.
// - Fetch from an I/O region faults with code 1.
// - Speculative accesses to I/O regions are never issued.
// - Misaligned load or store to I/O faults with code 5 or 7.
// - Split or merged load or store to I/O faults with code 5 or 7.
// - Stack push and pop accesses to I/O fault on the first offending access.
// - Bufferable stores set memory-type bit 0; fetches, loads, atomics do not.
// - Non-atomic bufferable stores are steered to the write buffer.
// - Cacheable accesses set memory-type bit 1.
// - Checksums checked only with global enable and region integrity flag.
// - Integrity errors raise the major alert; response-phase errors also raise an access-type fault or NMI, grant parity errors do not.
// - With no regions every address is plain main memory.
// - With regions, an unmatched address is plain I/O.
// - Every fetch, load and store is checked; nothing disables checking.
// - Debug-mode accesses in the debug window are plain main memory, no atomics.
// - Grant and response-valid parity are always checked.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module pma_checker #(
  parameter int                                               NumRegions = 16,
  parameter pma_pkg::pma_region_t [pma_pkg::MAX_REGIONS-1:0] RegionCfg  = '0,
  parameter logic [31:0] DebugWindowBase  = pma_pkg::DEBUG_BASE_DEFAULT,
  parameter logic [31:0] DebugWindowLimit = pma_pkg::DEBUG_LIMIT_DEFAULT
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        accValid,
  input  wire logic [31:0] accAddr,
  input  wire logic [1:0]  accKind,
  input  wire logic [1:0]  accSize,
  input  wire logic        accModified,
  input  wire logic        accAtomic,
  input  wire logic        accSpeculative,
  input  wire logic        accStackInstr,
  input  wire logic        debugMode,
  output logic             accFault,
  output logic [4:0]       accExcCode,
  output logic             accIssue,
  output logic [1:0]       memType,
  output logic             useWriteBuffer,
  output logic             atomicAllowed,
  input  wire logic        obiGnt,
  input  wire logic        obiGntPar,
  input  wire logic        obiRvalid,
  input  wire logic        obiRvalidPar,
  input  wire logic [31:0] obiRdata,
  input  wire logic        obiErr,
  input  wire logic [4:0]  obiRchk,
  output logic             alertMajor,
  output logic             instrParityFault,
  output logic             loadParityNmi,
  output logic             storeParityNmi
);

  // Attribute lookup: a priority chain from the highest region down to region 0.
  logic [NumRegions:0] chainMain;
  logic [NumRegions:0] chainBuf;
  logic [NumRegions:0] chainCache;
  logic [NumRegions:0] chainInteg;
  logic [NumRegions:0] hitVec;
  wire  [33:0]         addrWide = {2'b00, accAddr};

  assign chainMain[NumRegions]  = (NumRegions == 0);
  assign chainBuf[NumRegions]   = 1'b0;
  assign chainCache[NumRegions] = 1'b0;
  assign chainInteg[NumRegions] = 1'b0;
  assign hitVec[NumRegions]     = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < NumRegions; gi++) begin : g_region
      wire regionHit = (addrWide >= {RegionCfg[gi].wordAddrLow, 2'b00}) &&
                       (addrWide < {RegionCfg[gi].wordAddrHigh, 2'b00});
      // A lower index overrides every higher one.
      assign chainMain[gi]  = regionHit ? RegionCfg[gi].main : chainMain[gi+1];
      assign chainBuf[gi]   = regionHit ? RegionCfg[gi].bufferable : chainBuf[gi+1];
      assign chainCache[gi] = regionHit ? RegionCfg[gi].cacheable : chainCache[gi+1];
      assign chainInteg[gi] = regionHit ? RegionCfg[gi].integrity : chainInteg[gi+1];
      assign hitVec[gi]     = regionHit;

      // The low bound itself lies inside a region and the high bound lies outside it.
      bound_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        addrWide[33:2] == RegionCfg[gi].wordAddrLow &&
          RegionCfg[gi].wordAddrLow < RegionCfg[gi].wordAddrHigh |-> regionHit)
        else $error("region low bound missed");

      bound_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
        addrWide[33:2] == RegionCfg[gi].wordAddrHigh |-> !regionHit)
        else $error("region high bound matched");
    end
  endgenerate

  wire debugHit  = debugMode && (accAddr >= DebugWindowBase) &&
                   (accAddr <= DebugWindowLimit);
  wire attrMain  = debugHit | chainMain[0];
  wire attrBuf   = !debugHit && chainBuf[0];
  wire attrCache = !debugHit && chainCache[0];
  wire attrInteg = !debugHit && chainInteg[0];

  wire isFetch = (accKind == pma_pkg::KIND_FETCH);
  wire isLoad  = (accKind == pma_pkg::KIND_LOAD);
  wire isStore = (accKind == pma_pkg::KIND_STORE);

  wire misaligned = ((accSize == pma_pkg::SIZE_HALF) && accAddr[0]) ||
                    ((accSize == pma_pkg::SIZE_WORD) && (accAddr[1:0] != 2'b00));

  // Main memory tolerates all of these; I/O tolerates none.
  wire dataBad    = misaligned | accModified | accStackInstr;
  wire fetchFault = isFetch && !attrMain;
  wire loadFault  = isLoad && !attrMain && dataBad;
  wire storeFault = isStore && !attrMain && dataBad;
  wire anyFault   = accValid && (fetchFault || loadFault || storeFault);

  assign accFault   = anyFault;
  assign accExcCode = !anyFault  ? pma_pkg::EXC_NONE :
                      fetchFault ? pma_pkg::EXC_INSTR_ACCESS :
                      loadFault  ? pma_pkg::EXC_LOAD_ACCESS :
                                   pma_pkg::EXC_STORE_ACCESS;
  // Speculation into non-idempotent space is held back without a fault.
  assign accIssue = accValid && !anyFault &&
                    !(accSpeculative && !attrMain);

  wire bufStore = isStore && attrBuf && !accAtomic;
  assign memType[pma_pkg::MEMTYPE_BUF_BIT]   = accValid && bufStore;
  assign memType[pma_pkg::MEMTYPE_CACHE_BIT] = accValid && attrCache;
  assign useWriteBuffer = accValid && bufStore;
  assign atomicAllowed  = accValid && attrMain && !debugHit;

  // Register block.
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic        integSeen_reg;
  logic        integSeen_next;
  logic        faultSeen_reg;
  logic        faultSeen_next;
  logic [4:0]  lastCode_reg;
  logic [4:0]  lastCode_next;
  logic [31:0] faultAddr_reg;
  logic [31:0] faultAddr_next;
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic [31:0] hrdata_reg;

  // Response tracking for the integrity checks.
  logic        rspInteg_reg;
  logic [1:0]  rspKind_reg;
  logic        alert_reg;
  logic        instrPar_reg;
  logic        loadPar_reg;
  logic        storePar_reg;

  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] busOfs = {haddr[7:2], 2'b00};
  wire wrCtrl   = wrPend_reg && (wrAddr_reg == pma_pkg::OFS_CTRL);
  wire wrStatus = wrPend_reg && (wrAddr_reg == pma_pkg::OFS_STATUS);
  wire integOn  = ctrl_reg[pma_pkg::CTRL_INTEGRITY_BIT];

  // Parity runs on every cycle out of reset; checksums only where enabled.
  wire gntParErr    = (obiGntPar == obiGnt);
  wire rvalidParErr = (obiRvalidPar == obiRvalid);
  wire [4:0] rchkExpect = {obiErr, ^obiRdata[31:24], ^obiRdata[23:16],
                           ^obiRdata[15:8], ^obiRdata[7:0]};
  wire rspRead  = (rspKind_reg != pma_pkg::KIND_STORE);
  wire chkDiff  = rspRead ? (obiRchk != rchkExpect) : (obiRchk[4] != obiErr);
  wire chkErr   = obiRvalid && integOn && rspInteg_reg && chkDiff;
  wire rspErr   = obiRvalid && (rvalidParErr || chkErr);
  wire integErr = gntParErr || rvalidParErr || chkErr;

  assign ctrl_next = wrCtrl ? hwdata : ctrl_reg;
  // Hardware set wins over a write-one clear in the same cycle.
  assign integSeen_next = integErr ||
                          (integSeen_reg && !(wrStatus && hwdata[pma_pkg::STATUS_INTEG_BIT]));
  assign faultSeen_next = anyFault ||
                          (faultSeen_reg && !(wrStatus && hwdata[pma_pkg::STATUS_FAULT_BIT]));
  assign lastCode_next  = anyFault ? accExcCode : lastCode_reg;
  assign faultAddr_next = anyFault ? accAddr : faultAddr_reg;

  wire [31:0] statusNext = ({27'h0, lastCode_next} << pma_pkg::STATUS_CODE_LSB) |
                           ({31'h0, faultSeen_next} << pma_pkg::STATUS_FAULT_BIT) |
                           ({31'h0, integSeen_next} << pma_pkg::STATUS_INTEG_BIT);
  // Reads see the value after any write still in its data phase.
  wire [31:0] readMux = (busOfs == pma_pkg::OFS_CTRL)       ? ctrl_next :
                        (busOfs == pma_pkg::OFS_STATUS)     ? statusNext :
                        (busOfs == pma_pkg::OFS_FAULT_ADDR) ? faultAddr_next :
                                                              32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg      <= pma_pkg::CTRL_RESET;
      integSeen_reg <= 1'b0;
      faultSeen_reg <= 1'b0;
      lastCode_reg  <= pma_pkg::EXC_NONE;
      faultAddr_reg <= pma_pkg::FAULT_ADDR_RESET;
    end else begin
      ctrl_reg      <= ctrl_next;
      integSeen_reg <= integSeen_next;
      faultSeen_reg <= faultSeen_next;
      lastCode_reg  <= lastCode_next;
      faultAddr_reg <= faultAddr_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= addrPhase ? busOfs : wrAddr_reg;
      hrdata_reg <= (addrPhase && !hwrite) ? readMux : hrdata_reg;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rspInteg_reg <= 1'b0;
      rspKind_reg  <= pma_pkg::KIND_FETCH;
    end else if (accIssue && obiGnt) begin
      rspInteg_reg <= attrInteg;
      rspKind_reg  <= accKind;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_reg    <= 1'b0;
      instrPar_reg <= 1'b0;
      loadPar_reg  <= 1'b0;
      storePar_reg <= 1'b0;
    end else begin
      alert_reg    <= integErr;
      instrPar_reg <= rspErr && (rspKind_reg == pma_pkg::KIND_FETCH);
      loadPar_reg  <= rspErr && (rspKind_reg == pma_pkg::KIND_LOAD);
      storePar_reg <= rspErr && (rspKind_reg == pma_pkg::KIND_STORE);
    end
  end

  assign alertMajor       = alert_reg;
  assign instrParityFault = instrPar_reg;
  assign loadParityNmi    = loadPar_reg;
  assign storeParityNmi   = storePar_reg;

  // Checks on the attribution results, the integrity alert and the captured fault status.
  fetch_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && isFetch && !attrMain |-> accFault && accExcCode == 5'h01)
    else $error("fetch from I/O did not fault with code 1");

  load_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && isLoad && !attrMain && misaligned |-> accExcCode == 5'h05 && !accIssue)
    else $error("misaligned I/O load did not fault with code 5");

  store_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && isStore && !attrMain && accModified |-> accExcCode == 5'h07 && !accIssue)
    else $error("modified I/O store did not fault with code 7");

  main_ok_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && attrMain |-> !accFault)
    else $error("main memory access faulted");

  spec_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accIssue && accSpeculative |-> attrMain)
    else $error("speculative access issued to I/O");

  buf_type_a: assert property (@(posedge mclk) disable iff (!rst_n)
    memType[0] |-> isStore && !accAtomic && useWriteBuffer)
    else $error("bufferable bit set outside a plain store");

  debug_win_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && debugHit |-> !accFault && memType == 2'b00 && !atomicAllowed)
    else $error("debug window access not plain main memory");

  alert_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    integErr |=> alertMajor ##1 (integSeen_reg || $past(wrStatus)))
    else $error("integrity error did not raise the alert");

  chk_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    obiRvalid && (!integOn || !rspInteg_reg) && !rvalidParErr && !gntParErr
      |=> !alertMajor)
    else $error("checksum checked while disabled");

  par_always_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(gntParErr) |=> alertMajor)
    else $error("grant parity error not flagged");

  sticky_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    anyFault |=> faultSeen_reg && faultAddr_reg == $past(accAddr))
    else $error("fault not captured in status");

  // Checks on fault coding, request steering, region priority and default attribution.
  stack_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && (isLoad || isStore) && !attrMain && accStackInstr |-> accFault && !accIssue)
    else $error("stack instruction access to I/O not faulted");

  modif_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && isLoad && !attrMain && accModified |-> accExcCode == pma_pkg::EXC_LOAD_ACCESS)
    else $error("modified I/O load did not fault with code 5");

  misal_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && isStore && !attrMain && accSize == pma_pkg::SIZE_HALF && accAddr[0]
      |-> accExcCode == pma_pkg::EXC_STORE_ACCESS)
    else $error("misaligned I/O store did not fault with code 7");

  wbuf_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
    useWriteBuffer |-> memType[pma_pkg::MEMTYPE_BUF_BIT] && isStore && !accAtomic)
    else $error("write buffer used outside a bufferable store");

  issue_ok_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accIssue |-> accValid && !accFault)
    else $error("faulting access issued");

  code_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accFault == (accExcCode != pma_pkg::EXC_NONE))
    else $error("fault flag and code disagree");

  idle_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !accValid |-> !accFault && !accIssue && memType == 2'b00 &&
      !useWriteBuffer && !atomicAllowed)
    else $error("attribution outputs active without an access");

  prio_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && !debugHit && hitVec[0] |-> attrMain == RegionCfg[0].main &&
      attrCache == RegionCfg[0].cacheable)
    else $error("region 0 did not take priority");

  unmatched_io_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && !debugHit && NumRegions > 0 && hitVec == '0 |-> !attrMain && memType == 2'b00)
    else $error("unmatched address not plain I/O");

  empty_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accValid && NumRegions == 0 |-> accIssue && !accFault && memType == 2'b00)
    else $error("empty map not plain main memory");

  // Checks on the integrity responses and the pulses they raise.
  rvalid_par_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rvalidParErr |=> alertMajor)
    else $error("response-valid parity error not flagged");

  instr_par_a: assert property (@(posedge mclk) disable iff (!rst_n)
    obiRvalid && rvalidParErr && rspKind_reg == pma_pkg::KIND_FETCH |=> instrParityFault)
    else $error("fetch response error without parity fault");

  load_nmi_a: assert property (@(posedge mclk) disable iff (!rst_n)
    obiRvalid && rvalidParErr && rspKind_reg == pma_pkg::KIND_LOAD |=> loadParityNmi)
    else $error("load response error without NMI");

  store_nmi_a: assert property (@(posedge mclk) disable iff (!rst_n)
    obiRvalid && rvalidParErr && rspKind_reg == pma_pkg::KIND_STORE |=> storeParityNmi)
    else $error("store response error without NMI");

  kind_alert_a: assert property (@(posedge mclk) disable iff (!rst_n)
    instrParityFault || loadParityNmi || storeParityNmi |-> alertMajor)
    else $error("parity fault without major alert");

  store_chk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    obiRvalid && rspKind_reg == pma_pkg::KIND_STORE && obiRchk[4] == obiErr &&
      !rvalidParErr && !gntParErr |=> !alertMajor)
    else $error("store response data checksum checked");

endmodule

// >>> bench/pma_obi_model.sv
// Behavioural OBI responder standing in for the bus beyond the checker.
`timescale 1ns/1ps

module pma_obi_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        gntReq,
  input  wire logic        rspReq,
  input  wire logic [2:0]  badSel,
  input  wire logic [31:0] rspData,
  output logic             obiGnt,
  output logic             obiGntPar,
  output logic             obiRvalid,
  output logic             obiRvalidPar,
  output logic [31:0]      obiRdata,
  output logic             obiErr,
  output logic [4:0]       obiRchk
);
  logic [31:0] idleData;

  // Outside a response the data lines carry a pattern that flips every cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idleData <= 32'h0000_0000;
    end else begin
      idleData <= ~obiRdata;
    end
  end

  assign obiGnt       = gntReq;
  assign obiGntPar    = ~gntReq ^ badSel[0];
  assign obiRvalid    = rspReq;
  assign obiRvalidPar = ~rspReq ^ badSel[1];
  assign obiRdata     = rspReq ? rspData : idleData;
  assign obiErr       = 1'b0;
  assign obiRchk      = {obiErr ^ badSel[2], ^obiRdata[31:24], ^obiRdata[23:16],
                         ^obiRdata[15:8], ^obiRdata[7:0]};
endmodule

// >>> bench/physical_memory_attribution_tb.sv
// Self-checking testbench of the memory attribution checker.
`timescale 1ns/1ps

module physical_memory_attribution_tb;
  localparam pma_pkg::pma_region_t [pma_pkg::MAX_REGIONS-1:0] Cfg = {{13{68'h0}},
    {32'h0000_1000, 32'h0000_1400, 4'hA}, {32'h0000_0600, 32'h0000_0C00, 4'h6},
    {32'h0000_0400, 32'h0000_0800, 4'hF}};
  logic        mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp, accValid, accModified;
  logic        accAtomic, accSpeculative, accStackInstr, debugMode, accFault, accIssue;
  logic        useWriteBuffer, atomicAllowed, gntReq, rspReq, alertMajor, instrParityFault;
  logic        loadParityNmi, storeParityNmi, obiGnt, obiGntPar, obiRvalid, obiRvalidPar;
  logic        obiErr, ctrlEn, anyFault;
  logic [1:0]  htrans, accKind, accSize, memType;
  logic [2:0]  hsize, badSel;
  logic [4:0]  accExcCode, obiRchk, lastCode;
  logic [31:0] haddr, hwdata, hrdata, accAddr, obiRdata, rspData, lastAddr, r;
  logic [31:0] rng = 32'h34B3;
  logic [31:0] lo [3] = '{32'h0000_1000, 32'h0000_1800, 32'h0000_4000};
  logic [31:0] hi [3] = '{32'h0000_2000, 32'h0000_3000, 32'h0000_5000};
  logic [3:0]  fl [3] = '{4'hF, 4'h6, 4'hA};
  logic [31:0] pts [13] = '{32'h0000_0FFC, 32'h0000_1000, 32'h0000_17FC, 32'h0000_1800,
    32'h0000_1FFC, 32'h0000_2000, 32'h0000_2FFC, 32'h0000_3000, 32'h0000_3FFC,
    32'h0000_4FFC, 32'h0000_8000, 32'h0000_8FFC, 32'h0000_9000};
  int          nErrors, cmpCount;
  logic        flatFault, flatIssue, flatAtomic;
  logic [1:0]  flatType;

  assign hready = hreadyout;

  pma_checker #(.NumRegions(3), .RegionCfg(Cfg)) dut (.mclk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .accValid,
    .accAddr, .accKind, .accSize, .accModified, .accAtomic, .accSpeculative,
    .accStackInstr, .debugMode, .accFault, .accExcCode, .accIssue, .memType,
    .useWriteBuffer, .atomicAllowed, .obiGnt, .obiGntPar, .obiRvalid, .obiRvalidPar,
    .obiRdata, .obiErr, .obiRchk, .alertMajor, .instrParityFault, .loadParityNmi,
    .storeParityNmi);

  pma_obi_model far (.mclk, .rst_n, .gntReq, .rspReq, .badSel, .rspData, .obiGnt,
    .obiGntPar, .obiRvalid, .obiRvalidPar, .obiRdata, .obiErr, .obiRchk);

  // A second checker with no regions shows the flat default map.
  pma_checker #(.NumRegions(0)) dutFlat (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout(), .hrdata(), .hresp(), .accValid, .accAddr,
    .accKind, .accSize, .accModified, .accAtomic, .accSpeculative, .accStackInstr,
    .debugMode, .accFault(flatFault), .accExcCode(), .accIssue(flatIssue),
    .memType(flatType), .useWriteBuffer(), .atomicAllowed(flatAtomic), .obiGnt, .obiGntPar,
    .obiRvalid, .obiRvalidPar, .obiRdata, .obiErr, .obiRchk, .alertMajor(),
    .instrParityFault(), .loadParityNmi(), .storeParityNmi());

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Flags are main, bufferable, cacheable, integrity from bit 3 down.
  function automatic logic [3:0] attr(input logic [31:0] a, input logic win);
    if (win) return 4'h8;
    for (int i = 0; i < 3; i++) if (a >= lo[i] && a < hi[i]) return fl[i];
    return 4'h0;
  endfunction

  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmpCount++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      nErrors++;
    end
  endtask

  task automatic waitRdy();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hready !== 1'b1 && k < 16);
    if (hready !== 1'b1) begin
      nErrors++;
      wrapUp();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] o, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(o);
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    r = hrdata;
  endtask

  task automatic rdChk(input logic [7:0] o, input logic [31:0] ex);
    ahb(1'b0, o, 32'h0);
    chk("register read", ex, r);
  endtask

  task automatic accChk();
    logic [3:0] f;
    logic       mis, win, bufSt;
    logic [4:0] code;
    win = debugMode && accAddr >= pma_pkg::DEBUG_BASE_DEFAULT
          && accAddr <= pma_pkg::DEBUG_LIMIT_DEFAULT;
    f = attr(accAddr, win);
    mis = (accSize == pma_pkg::SIZE_HALF && accAddr[0])
          || (accSize == pma_pkg::SIZE_WORD && accAddr[1:0] != 2'h0);
    bufSt = f[2] && accKind == pma_pkg::KIND_STORE && !accAtomic;
    code = 5'h00;
    if (!f[3]) begin
      if (accKind == pma_pkg::KIND_FETCH) code = 5'h01;
      else if (mis || accModified || accStackInstr)
        code = (accKind == pma_pkg::KIND_LOAD) ? 5'h05 : 5'h07;
    end
    chk("access", 32'({code != 5'h00, code, code == 5'h00 && (f[3] || !accSpeculative),
        f[1], bufSt, bufSt, f[3] && !win}), 32'({accFault, accExcCode, accIssue, memType,
        useWriteBuffer, atomicAllowed}));
    chk("flat map", 32'({1'b0, 1'b1, 2'b00, !win}),
        32'({flatFault, flatIssue, flatType, flatAtomic}));
    if (code != 5'h00) begin
      anyFault = 1'b1;
      lastCode = code;
      lastAddr = accAddr;
    end
  endtask

  task automatic integ(input logic [31:0] a, input logic [1:0] k, input logic [2:0] bad);
    logic [3:0] f;
    logic       e;
    f = attr(a, 1'b0);
    e = bad[1] || (bad[2] && ctrlEn && f[0]);
    {accValid, gntReq, accAddr, accKind, accSize} <= {2'b11, a, k, pma_pkg::SIZE_WORD};
    badSel <= {2'b00, bad[0]};
    @(posedge mclk);
    {accValid, gntReq, rspReq, badSel} <= {3'b001, bad[2:1], 1'b0};
    rspData <= xs();
    @(negedge mclk);
    chk("alert after grant", 32'(bad[0]), 32'(alertMajor));
    @(posedge mclk);
    {rspReq, badSel} <= 4'h0;
    @(negedge mclk);
    chk("alert and kind", 32'({e, e && k == 2'h0, e && k == 2'h1, e && k == 2'h2}),
        32'({alertMajor, instrParityFault, loadParityNmi, storeParityNmi}));
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #10_000_000;
    nErrors++;
    wrapUp();
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata, gntReq, rspReq, badSel} = '0;
    {accValid, accAddr, accKind, accSize, accModified, accAtomic} = '0;
    {accSpeculative, accStackInstr, debugMode, rspData, lastAddr, lastCode} = '0;
    {anyFault, ctrlEn, nErrors, cmpCount} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk(pma_pkg::OFS_CTRL, pma_pkg::CTRL_RESET);
    rdChk(pma_pkg::OFS_STATUS, 32'h0);
    rdChk(pma_pkg::OFS_FAULT_ADDR, pma_pkg::FAULT_ADDR_RESET);
    $display("test reset values done");
    for (int i = 0; i < 400; i++) begin
      r = xs();
      accValid <= 1'b1;
      accAddr <= pts[r[7:4] % 13] + 32'(r[9:8]);
      accKind <= 2'(r[11:10] % 3);
      accSize <= 2'(r[13:12] % 3);
      {accModified, accAtomic, accSpeculative, accStackInstr, debugMode} <= r[18:14];
      @(negedge mclk);
      accChk();
      @(posedge mclk);
    end
    {accValid, debugMode, accSpeculative, accModified, accStackInstr, accAtomic} <= '0;
    $display("test random accesses done");
    rdChk(pma_pkg::OFS_FAULT_ADDR, lastAddr);
    rdChk(pma_pkg::OFS_STATUS, {19'h0, lastCode, 6'h0, anyFault, 1'b0});
    ahb(1'b1, pma_pkg::OFS_STATUS, 32'h0000_0003);
    rdChk(pma_pkg::OFS_STATUS, {19'h0, lastCode, 8'h0});
    ahb(1'b1, pma_pkg::OFS_CTRL, 32'hA5A5_5A5A);
    rdChk(pma_pkg::OFS_CTRL, 32'hA5A5_5A5A);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rdChk(8'h0C, 32'h0);
    $display("test registers done");
    integ(32'h0000_1000, pma_pkg::KIND_LOAD, 3'b100);
    integ(32'h0000_1000, pma_pkg::KIND_STORE, 3'b010);
    ahb(1'b1, pma_pkg::OFS_CTRL, 32'h0000_0001);
    ctrlEn = 1'b1;
    for (int k = 0; k < 3; k++) integ(32'h0000_1000, 2'(k), 3'b100);
    integ(32'h0000_4000, pma_pkg::KIND_LOAD, 3'b100);
    integ(32'h0000_1800, pma_pkg::KIND_LOAD, 3'b100);
    integ(32'h0000_1000, pma_pkg::KIND_LOAD, 3'b001);
    rdChk(pma_pkg::OFS_STATUS, {19'h0, lastCode, 8'h01});
    $display("test integrity done");
    wrapUp();
  end
endmodule
